/* File: hdl/adc_demux_consts.svh */
// Constants for the converter output demultiplexer and its sample buffer.
`ifndef ADC_DEMUX_CONSTS_SVH
`define ADC_DEMUX_CONSTS_SVH
`define WORD_W               6
`define OVERRANGE_OUTPUT_BIT 6
`define SAMPLE_LSB_OUTPUT    0
`define FIFO_DEPTH           16
`define PIPE_LAT             2
`define MSB_FLIP             6'h20
`define TEST_PATTERN_1       7'h55
`define TEST_PATTERN_2       7'h2A
`endif

/* File: hdl/adc_demux_pkg.sv */
// Types shared by the converter output demultiplexer.
`include "adc_demux_consts.svh"
package adc_demux_pkg;
  typedef struct packed {
    logic                overrange;
    logic [`WORD_W-1:0] word;
  } sample_t;
  typedef enum logic [1:0] {FMT_STRAIGHT, FMT_INVERTED, FMT_TWOS, FMT_INV_TWOS} format_t;
  typedef enum logic {BANK_A, BANK_B} bank_sel_t;
endpackage

/* File: hdl/adc_output_demux.sv */
// Converter output stage: sample buffer, two-bank demultiplexer and test patterns.
//
// How it works
// RQ1: Two output banks, each a 6-bit sample word plus one overrange bit.
// RQ2: Each bank updates every second sample clock; banks alternate in opposite phase.
// RQ3: Each bank has a differential strobe; receivers latch that bank with it.
// RQ4: Output words use straight, inverted, two's complement or inverted two's complement.
// RQ5: The divide-by-two starts defined so bank A gives the first output.
// RQ6: With test mode low, banks carry conversion results.
// RQ7: With test mode high, output latches carry fixed test patterns instead.
// RQ8: The first pattern appears at the first sample edge after test mode rises; here at the third, after the two-flop pin synchroniser.
// RQ9: While test mode stays high, the two patterns alternate.
// RQ10: Conversion stages before the output stage keep running during test mode.
// RQ11: Real data returns at the first sample edge after test mode falls; here at the third, after the two-flop pin synchroniser.
// RQ12: Output data appears two sample clocks after its sample is taken.
// RQ13: Pattern one is 1010101 from the overrange bit down; pattern two its complement.
// RQ14: Bit six of each bank is the overrange flag, bits five to zero the word.
// RQ15: Strobes keep toggling in test mode so capture logic takes the patterns.
`timescale 1ns/1ps
`default_nettype none
`include "adc_demux_consts.svh"

// ----------------------------------------------------------------------------
// Dual-clock sample buffer
// ----------------------------------------------------------------------------
module sample_fifo
  import adc_demux_pkg::*;
#(
  parameter int WIDTH = 7,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             wr_clk,
  input  wire logic             wr_rst,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic             rd_clk,
  input  wire logic             rd_rst,
  output logic [WIDTH-1:0]      rd_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sample_fifo depth must be a power of two of at least four");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW:0]      wbin_q, wbin_d, wgray_q, wgray_d;
  logic [AW:0]      rbin_q, rbin_d, rgray_q, rgray_d;
  logic [AW:0]      rg_s1_q, rg_s2_q, wg_s1_q, wg_s2_q;
  logic             push, pop;

  // ----------------------------------------------------------------------------
  // Write side
  // ----------------------------------------------------------------------------
  // Full compares against the read pointer only after two flip-flops, so it may
  // report full a little late in freeing space, never early in taking it.
  assign wr_ready = wgray_q != {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]};
  assign push     = wr_valid && wr_ready;

  always_comb begin
    mem_d   = mem_q;
    wbin_d  = wbin_q;
    if (push) begin
      mem_d[wbin_q[AW-1:0]] = wr_data;
      wbin_d                = wbin_q + 1'b1;
    end
    wgray_d = wbin_d ^ (wbin_d >> 1);
  end

  always_ff @(posedge wr_clk or posedge wr_rst) begin
    if (wr_rst) begin
      mem_q   <= '{default: '0};
      wbin_q  <= '0;
      wgray_q <= '0;
      rg_s1_q <= '0;
      rg_s2_q <= '0;
    end else begin
      mem_q   <= mem_d;
      wbin_q  <= wbin_d;
      wgray_q <= wgray_d;
      rg_s1_q <= rgray_q;
      rg_s2_q <= rg_s1_q;
    end
  end

  // ----------------------------------------------------------------------------
  // Read side
  // ----------------------------------------------------------------------------
  assign rd_valid = rgray_q != wg_s2_q;
  assign rd_data  = mem_q[rbin_q[AW-1:0]];
  assign pop      = rd_valid && rd_ready;

  always_comb begin
    rbin_d  = pop ? rbin_q + 1'b1 : rbin_q;
    rgray_d = rbin_d ^ (rbin_d >> 1);
  end

  always_ff @(posedge rd_clk or posedge rd_rst) begin
    if (rd_rst) begin
      rbin_q  <= '0;
      rgray_q <= '0;
      wg_s1_q <= '0;
      wg_s2_q <= '0;
    end else begin
      rbin_q  <= rbin_d;
      rgray_q <= rgray_d;
      wg_s1_q <= wgray_q;
      wg_s2_q <= wg_s1_q;
    end
  end
endmodule

// ----------------------------------------------------------------------------
// Output demultiplexer top
// ----------------------------------------------------------------------------
module adc_output_demux
  import adc_demux_pkg::*;
#(
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire sample_t    sample_in,
  input  wire logic       sample_valid,
  output logic            sample_ready,
  input  wire logic       sample_clk,
  input  wire logic       run,
  input  wire logic       test_mode,
  input  wire logic [1:0] format_sel,
  output sample_t         bank_a_data,
  output logic            bank_a_strobe,
  output logic            bank_a_strobe_n,
  output sample_t         bank_b_data,
  output logic            bank_b_strobe,
  output logic            bank_b_strobe_n
);
  // ----------------------------------------------------------------------------
  // Reset and pin synchronisers on the sample clock
  // ----------------------------------------------------------------------------
  logic [1:0] lrst_q, lrst_d;
  logic [3:0] pin_s1_q, pin_s2_q;
  logic       link_rst, run_s, test_s;
  format_t    fmt_s;

  assign lrst_d   = {lrst_q[0], 1'b0};
  assign link_rst = lrst_q[1];
  assign run_s    = pin_s2_q[3];
  assign test_s   = pin_s2_q[2];
  assign fmt_s    = format_t'(pin_s2_q[1:0]);

  always_ff @(posedge sample_clk or posedge reset) begin
    if (reset) begin
      lrst_q   <= 2'h3;
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end else begin
      lrst_q   <= lrst_d;
      pin_s1_q <= {run, test_mode, format_sel};
      pin_s2_q <= pin_s1_q;
    end
  end

  // ----------------------------------------------------------------------------
  // Buffer between the sample source and the sample clock
  // ----------------------------------------------------------------------------
  sample_t fifo_word;
  logic    fifo_valid, pop;

  // Dropping run stalls the drain; the buffer then fills and holds off the source.
  assign pop = fifo_valid && run_s;

  sample_fifo #(
    .WIDTH ($bits(sample_t)),
    .DEPTH (DEPTH)
  ) i_sample_fifo (
    .wr_clk   (clk),
    .wr_rst   (reset),
    .wr_data  (sample_in),
    .wr_valid (sample_valid),
    .wr_ready (sample_ready),
    .rd_clk   (sample_clk),
    .rd_rst   (link_rst),
    .rd_data  (fifo_word),
    .rd_valid (fifo_valid),
    .rd_ready (run_s)
  );

  // ----------------------------------------------------------------------------
  // Output coding
  // ----------------------------------------------------------------------------
  function automatic sample_t encode(sample_t s, format_t f);
    sample_t r;
    r = s;
    case (f)
      FMT_INVERTED: r.word = ~s.word;
      FMT_TWOS:     r.word = s.word ^ `MSB_FLIP;
      FMT_INV_TWOS: r.word = ~(s.word ^ `MSB_FLIP);
      default:      r.word = s.word;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------------------
  // Pipeline, bank select and output latches
  // ----------------------------------------------------------------------------
  sample_t   s1_q, s1_d, s2_q, s2_d, enc_word, out_val;
  sample_t   bank_a_q, bank_a_d, bank_b_q, bank_b_d, last_out_q, last_out_d;
  logic      s1_vld_q, s1_vld_d, s2_vld_q, s2_vld_d, upd;
  logic      pat_q, pat_d, str_a_q, str_a_d, str_b_q, str_b_d;
  logic      upd_a_q, upd_a_d, upd_b_q, upd_b_d, first_done_q, first_done_d;
  bank_sel_t sel_q, sel_d;

  always_comb begin
    s1_d         = pop ? fifo_word : s1_q;
    s1_vld_d     = pop;                                            // RQ10
    s2_d         = s1_q;
    s2_vld_d     = s1_vld_q;                                       // RQ12
    enc_word     = encode(s2_q, fmt_s);                            // RQ4
    upd          = test_s || s2_vld_q;                             // RQ8 RQ11
    // Patterns replace the latch input only; the stages above keep converting.
    out_val      = test_s ? sample_t'(pat_q ? `TEST_PATTERN_2 : `TEST_PATTERN_1) : enc_word; // RQ7 RQ13
    pat_d        = test_s && !pat_q;                               // RQ9
    sel_d        = sel_q;
    bank_a_d     = bank_a_q;
    bank_b_d     = bank_b_q;
    str_a_d      = str_a_q;
    str_b_d      = str_b_q;
    upd_a_d      = 1'b0;
    upd_b_d      = 1'b0;
    last_out_d   = last_out_q;
    // Lags the bank loads by one edge so the very first load is still seen as first.
    first_done_d = first_done_q || upd_a_q || upd_b_q;
    if (upd) begin
      last_out_d = out_val;
      sel_d      = (sel_q == BANK_A) ? BANK_B : BANK_A;            // RQ2
      if (sel_q == BANK_A) begin
        bank_a_d = out_val;                                        // RQ6
        str_a_d  = 1'b1;                                           // RQ15
        str_b_d  = 1'b0;
        upd_a_d  = 1'b1;
      end else begin
        bank_b_d = out_val;
        str_a_d  = 1'b0;
        str_b_d  = 1'b1;                                           // RQ3
        upd_b_d  = 1'b1;
      end
    end
  end

  always_ff @(posedge sample_clk or posedge link_rst) begin
    if (link_rst) begin
      s1_q         <= '0;
      s1_vld_q     <= 1'b0;
      s2_q         <= '0;
      s2_vld_q     <= 1'b0;
      pat_q        <= 1'b0;
      sel_q        <= BANK_A;                                      // RQ5
      bank_a_q     <= '0;
      bank_b_q     <= '0;
      str_a_q      <= 1'b0;
      str_b_q      <= 1'b0;
      upd_a_q      <= 1'b0;
      upd_b_q      <= 1'b0;
      last_out_q   <= '0;
      first_done_q <= 1'b0;
    end else begin
      s1_q         <= s1_d;
      s1_vld_q     <= s1_vld_d;
      s2_q         <= s2_d;
      s2_vld_q     <= s2_vld_d;
      pat_q        <= pat_d;
      sel_q        <= sel_d;
      bank_a_q     <= bank_a_d;
      bank_b_q     <= bank_b_d;
      str_a_q      <= str_a_d;
      str_b_q      <= str_b_d;
      upd_a_q      <= upd_a_d;
      upd_b_q      <= upd_b_d;
      last_out_q   <= last_out_d;
      first_done_q <= first_done_d;
    end
  end

  assign bank_a_data     = bank_a_q;                               // RQ1
  assign bank_b_data     = bank_b_q;                               // RQ14
  assign bank_a_strobe   = str_a_q;
  assign bank_a_strobe_n = ~str_a_q;
  assign bank_b_strobe   = str_b_q;
  assign bank_b_strobe_n = ~str_b_q;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge sample_clk); endclocking
  default disable iff (link_rst);

  property p_bank_alternate;
    upd_a_q |=> !upd_a_q;
  endproperty
  a_bank_alternate: assert property (p_bank_alternate) else $error("bank A updated twice in a row"); // RQ2

  property p_strobe_follow;
    (upd_a_q |-> bank_a_strobe && !bank_b_strobe && bank_b_strobe_n) and
    (upd_b_q |-> bank_b_strobe && !bank_a_strobe && bank_a_strobe_n);
  endproperty
  a_strobe_follow: assert property (p_strobe_follow) else $error("strobe does not mark its bank"); // RQ3

  property p_first_bank_a;
    !first_done_q && (upd_a_q || upd_b_q) |-> upd_a_q;
  endproperty
  a_first_bank_a: assert property (p_first_bank_a) else $error("first output not on bank A"); // RQ5

  property p_latency;
    pop ##1 1'b1 ##1 !test_s |=> last_out_q == encode($past(fifo_word, 3), $past(fmt_s));
  endproperty
  a_latency: assert property (p_latency) else $error("output not two sample clocks after pop"); // RQ12

  property p_test_first;
    $rose(test_s) |=> (upd_a_q || upd_b_q) && last_out_q == sample_t'(`TEST_PATTERN_1);
  endproperty
  a_test_first: assert property (p_test_first) else $error("test mode did not start with pattern one"); // RQ8

  property p_test_alt;
    test_s && $past(test_s) |=> last_out_q == sample_t'(~$past(last_out_q));
  endproperty
  a_test_alt: assert property (p_test_alt) else $error("test patterns do not alternate"); // RQ13

  property p_resume;
    !test_s && $past(test_s) && s2_vld_q |=> last_out_q == $past(enc_word);
  endproperty
  a_resume: assert property (p_resume) else $error("data did not resume after test mode"); // RQ11

  property p_convert_on;
    pop |=> s1_vld_q ##1 s2_vld_q;
  endproperty
  a_convert_on: assert property (p_convert_on) else $error("pipeline stalled"); // RQ10

  property p_overrange;
    s2_vld_q && !test_s |=> last_out_q[`OVERRANGE_OUTPUT_BIT] == $past(s2_q.overrange);
  endproperty
  a_overrange: assert property (p_overrange) else $error("overrange bit misplaced"); // RQ14

  property p_inv_twos;
    s2_vld_q && !test_s && fmt_s == FMT_INV_TWOS |=> last_out_q.word == ~($past(s2_q.word) ^ `MSB_FLIP);
  endproperty
  a_inv_twos: assert property (p_inv_twos) else $error("inverted two's complement wrong"); // RQ4

  c_test_entry: cover property ($rose(test_s) ##1 upd_a_q ##1 upd_b_q);
  c_test_exit:  cover property ($fell(test_s) ##1 (upd_a_q || upd_b_q));
  c_stream:     cover property (upd_a_q ##1 upd_b_q ##1 upd_a_q ##1 upd_b_q);
endmodule
`default_nettype wire

/* File: verif/capture_model.sv */
// Downstream capture model that latches each output bank with its own strobe.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Capture logic
// ----------------------------------------------------------------------------
module capture_model
  import adc_demux_pkg::*;
(
  input  wire logic    sample_clk,
  input  wire logic    reset,
  input  wire sample_t bank_a_data,
  input  wire logic    bank_a_strobe,
  input  wire logic    bank_a_strobe_n,
  input  wire sample_t bank_b_data,
  input  wire logic    bank_b_strobe,
  input  wire logic    bank_b_strobe_n,
  output logic         cap_valid,
  output logic         cap_bank,
  output sample_t      cap_data,
  output logic         pair_ok
);
  logic a_q;
  logic b_q;

  // A bank is taken one sample clock after its strobe rises, while its data is held.
  // Waiting for the falling edge would lose the last word when the stream pauses.
  always @(posedge sample_clk or posedge reset) begin
    if (reset) begin
      a_q       <= 1'b0;
      b_q       <= 1'b0;
      cap_valid <= 1'b0;
      cap_bank  <= 1'b0;
      cap_data  <= '0;
      pair_ok   <= 1'b0;
    end else begin
      a_q       <= bank_a_strobe;
      b_q       <= bank_b_strobe;
      cap_valid <= (bank_a_strobe && !a_q) || (bank_b_strobe && !b_q);
      cap_bank  <= bank_b_strobe && !b_q;
      cap_data  <= (bank_b_strobe && !b_q) ? bank_b_data : bank_a_data;
      pair_ok   <= (bank_a_strobe_n === ~bank_a_strobe) && (bank_b_strobe_n === ~bank_b_strobe);
    end
  end
endmodule
`default_nettype wire

/* File: verif/adc_output_demux_test_pattern_bench.sv */
// Self-checking bench for the converter output demultiplexer.
`timescale 1ns/1ps
`default_nettype none
`include "adc_demux_consts.svh"

module adc_output_demux_test_pattern_bench;
  import adc_demux_pkg::*;
  localparam int DEPTH = `FIFO_DEPTH;
  logic      clk = 1'b0;
  logic      sample_clk = 1'b0;
  logic      reset = 1'b1;
  sample_t   sample_in;
  logic      sample_valid;
  logic      sample_ready;
  logic      run;
  logic      test_mode;
  logic [1:0] format_sel;
  sample_t   bank_a_data;
  sample_t   bank_b_data;
  logic      bank_a_strobe;
  logic      bank_a_strobe_n;
  logic      bank_b_strobe;
  logic      bank_b_strobe_n;
  logic      cap_valid;
  logic      cap_bank;
  sample_t   cap_data;
  logic      pair_ok;
  sample_t   exp_q[$];
  logic      exp_bank;
  logic      tm_on;
  sample_t   tm_next;
  int        tm_seen;
  int        err_total;
  int        total_checks;
  int        cyc;

  always #20 clk = ~clk;
  initial begin
    #5;
    forever #32 sample_clk = ~sample_clk;
  end

  adc_output_demux #(.DEPTH(DEPTH)) i_adc_output_demux (
    .clk(clk), .reset(reset), .sample_in(sample_in), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_clk(sample_clk), .run(run), .test_mode(test_mode),
    .format_sel(format_sel), .bank_a_data(bank_a_data), .bank_a_strobe(bank_a_strobe),
    .bank_a_strobe_n(bank_a_strobe_n), .bank_b_data(bank_b_data), .bank_b_strobe(bank_b_strobe),
    .bank_b_strobe_n(bank_b_strobe_n));

  capture_model i_capture_model (
    .sample_clk(sample_clk), .reset(reset), .bank_a_data(bank_a_data), .bank_a_strobe(bank_a_strobe),
    .bank_a_strobe_n(bank_a_strobe_n), .bank_b_data(bank_b_data), .bank_b_strobe(bank_b_strobe),
    .bank_b_strobe_n(bank_b_strobe_n), .cap_valid(cap_valid), .cap_bank(cap_bank),
    .cap_data(cap_data), .pair_ok(pair_ok));

  // ----------------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // The overrange bit is never recoded; only the word follows the format.
  function automatic sample_t fmt(input sample_t s, input logic [1:0] f);
    sample_t r;
    r = s;
    if (f[0]) r.word = ~r.word;
    if (f[1]) r.word = r.word ^ `MSB_FLIP;
    return r;
  endfunction

  // Offers n random words with random gaps; ready is read mid-cycle where it is settled.
  // Words sent with keep low are expected never to reach a bank.
  task automatic send(input int n, input logic keep = 1'b1);
    int k;
    k = 0;
    while (k < n) begin
      sample_in = sample_t'(7'($urandom));
      sample_valid = ($urandom % 4) != 0;
      if (sample_valid && sample_ready) begin
        if (keep) exp_q.push_back(fmt(sample_in, format_sel));
        k++;
      end
      @(negedge clk);
    end
    sample_valid = 1'b0;
  endtask

  task automatic drain();
    for (int i = 0; i < 600 && exp_q.size() != 0; i++) @(negedge clk);
    repeat (6) @(negedge clk);
    check(8'(exp_q.size()), 8'h00);
  endtask

  // ----------------------------------------------------------------------------
  // Watcher of captured banks
  // ----------------------------------------------------------------------------
  always @(posedge sample_clk) begin
    if (cap_valid === 1'b1) begin
      check({7'h00, cap_bank}, {7'h00, exp_bank});
      check({7'h00, pair_ok}, 8'h01);
      exp_bank = ~exp_bank;
      if (tm_on) begin
        check({1'b0, cap_data}, {1'b0, tm_next});
        tm_next = ~tm_next;
        tm_seen++;
      end else if (exp_q.size() == 0) check(8'hff, 8'h00);
      else check({1'b0, cap_data}, {1'b0, exp_q.pop_front()});
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    int acc;
    sample_in = '0;
    sample_valid = 1'b0;
    run = 1'b0;
    test_mode = 1'b0;
    format_sel = 2'h0;
    exp_bank = BANK_A;
    tm_on = 1'b0;
    tm_next = `TEST_PATTERN_1;
    tm_seen = 0;
    err_total = 0;
    total_checks = 0;
    cyc = 0;
    acc = 0;
    void'($urandom(55));
    // Reset is held two clock cycles; the link side is reset asynchronously meanwhile.
    repeat (2) @(negedge clk);
    check({4'h0, bank_a_strobe, bank_a_strobe_n, bank_b_strobe, bank_b_strobe_n}, 8'h05);
    check({1'b0, bank_a_data | bank_b_data}, 8'h00);
    reset = 1'b0;
    repeat (8) @(posedge sample_clk);
    @(negedge clk);
    // Output stage halted: the buffer takes exactly its depth and refuses the rest.
    repeat (24) begin
      sample_in = sample_t'(7'($urandom));
      sample_valid = 1'b1;
      if (sample_ready) begin
        exp_q.push_back(fmt(sample_in, format_sel));
        acc++;
      end
      @(negedge clk);
    end
    sample_valid = 1'b0;
    check(8'(acc), 8'(DEPTH));
    run = 1'b1;
    drain();
    for (int f = 0; f < 4; f++) begin
      format_sel = 2'(f);
      repeat (6) @(posedge sample_clk);
      @(negedge clk);
      send(12);
      drain();
    end
    tm_on = 1'b1;
    test_mode = 1'b1;
    // Words sent once patterns run must be converted and lost, never held back for later.
    repeat (4) @(posedge sample_clk);
    @(negedge clk);
    send(8, 1'b0);
    repeat (14) @(posedge sample_clk);
    @(negedge clk);
    test_mode = 1'b0;
    repeat (8) @(posedge sample_clk);
    @(negedge clk);
    tm_on = 1'b0;
    check(8'(tm_seen >= 8), 8'h01);
    send(10);
    drain();
    tally_and_finish();
  end
endmodule
`default_nettype wire
